//--- rtl/cwsd_edge_delay.sv
// delays the rising edge of a level by a programmed number of clocks
`timescale 1ns/10ps
module cwsd_edge_delay
    import cwsd_pkg::*;
#(
    parameter int WIDTH = CWSD_DB_WIDTH
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic levelIn,
    input wire logic [WIDTH-1:0] delayCount,
    output logic levelOut
);
    // elapsed clocks since the level rose
    logic [WIDTH-1:0] elapsed_q;
    // delayed level, high once the count has run out
    logic delayed_q;

    // count while the level is high; a low level drops the output at once
    always_ff @(posedge sys_clk)
    begin
        if (rst || !levelIn)
        begin
            elapsed_q <= '0;
            delayed_q <= 1'b0;
        end
        else if (!delayed_q)
        begin
            // level high for delayCount clocks, so N..N+1 counts of dead band
            if (elapsed_q == delayCount - WIDTH'(1))
            begin
                delayed_q <= 1'b1;
            end
            else
            begin
                elapsed_q <= elapsed_q + WIDTH'(1);
            end
        end
    end

    // a zero count bypasses the delay path entirely; otherwise the
    // output is gated by the live level so a fall drops it in the same
    // cycle, which keeps the full N counts between the two outputs
    always_comb
    begin
        if (delayCount == '0)
        begin
            levelOut = levelIn;
        end
        else
        begin
            levelOut = levelIn && delayed_q;
        end
    end
endmodule

//--- rtl/cwsd_pkg.sv
// shared constants for the shutdown and dead-band control block
package cwsd_pkg;
    // register byte addresses on the avalon slave
    localparam logic [4:0] CWSD_ADDR_SHUTDOWN_CTRL = 5'h00;
    localparam logic [4:0] CWSD_ADDR_RISE_COUNT = 5'h04;
    localparam logic [4:0] CWSD_ADDR_FALL_COUNT = 5'h08;
    localparam logic [4:0] CWSD_ADDR_IRQ_STATUS = 5'h0C;
    localparam logic [4:0] CWSD_ADDR_IRQ_ENABLE = 5'h10;
    localparam logic [4:0] CWSD_ADDR_IRQ_CLEAR = 5'h14;
    // shutdown control field positions
    localparam int CWSD_BIT_EVENT_FLAG = 7;
    localparam int CWSD_BIT_AUTO_RESTART = 6;
    localparam int CWSD_BIT_LC_ENABLE = 1;
    localparam int CWSD_BIT_FAULT_ENABLE = 0;
    // dead-band count width
    localparam int CWSD_DB_WIDTH = 6;
    // interrupt status bit positions
    localparam int CWSD_IRQ_SHUTDOWN = 0;
    localparam int CWSD_IRQ_RESTART = 1;
    localparam int CWSD_IRQ_WIDTH = 2;
    // values after reset
    localparam logic [7:0] CWSD_CTRL_RESET = 8'h00;
    localparam logic [5:0] CWSD_DB_POR_RESET = 6'h00;
    localparam logic [1:0] CWSD_IRQ_RESET = 2'h0;
    localparam logic [31:0] CWSD_READ_ZERO = 32'h0000_0000;
    // register selector used by the bus decode
    typedef enum logic [2:0]
    {
        CWSD_SEL_CTRL = 3'b000,
        CWSD_SEL_RISE = 3'b001,
        CWSD_SEL_FALL = 3'b010,
        CWSD_SEL_STAT = 3'b011,
        CWSD_SEL_ENAB = 3'b100,
        CWSD_SEL_CLR = 3'b101,
        CWSD_SEL_NONE = 3'b111
    } cwsd_sel_t;
endpackage

//--- rtl/cwsd_top.sv
// auto-shutdown control and dead-band timing with an avalon slave
// Summary of operation
// - enabled shutdown sets flag, disables both outputs
// - flag clear lets output enables act normally
// - restart enable bit allows or blocks restart
// - enabled logic cell high output causes shutdown
// - enabled fault input low causes shutdown
// - unimplemented control and count bits read zero
// - rising count N gives N..N+1 delay
// - falling count N delays; zero bypasses dead band
// - flag software writable, hardware set and clear
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module cwsd_top
    import cwsd_pkg::*;
#(
    parameter int DB_WIDTH = CWSD_DB_WIDTH
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic porRst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic waveIn,
    input wire logic output_a_enable,
    input wire logic output_b_enable,
    input wire logic logic_cell_one_output,
    input wire logic fault_input,
    output logic waveOutA,
    output logic waveOutB,
    output logic irq
);
    // synchroniser stages for the two shutdown sources
    logic lcMeta_q;
    logic lcSync_q;
    logic faultMeta_q;
    logic faultSync_q;
    // shutdown control bits
    logic shutdown_event_flag;
    logic auto_restart_enable;
    logic logic_cell_shutdown_enable;
    logic fault_shutdown_enable;
    // dead-band counts, never cleared by the ordinary reset
    logic [DB_WIDTH-1:0] rising_deadband_value;
    logic [DB_WIDTH-1:0] falling_deadband_value;
    // interrupt status and enable
    logic [CWSD_IRQ_WIDTH-1:0] irqStatus_q;
    logic [CWSD_IRQ_WIDTH-1:0] irqEnable_q;
    // bus handshake state
    logic ack_q;
    logic [31:0] readData_q;
    // decoded access
    cwsd_sel_t busSel;
    logic wrStrobe;
    logic lowByteWr;
    // shutdown source and hardware events
    logic sourceActive;
    logic hwSet;
    logic hwRestart;
    logic swCtlWr;
    // delayed waveforms before output gating
    logic delayedA;
    logic delayedB;
    // registered outputs
    logic waveOutA_q;
    logic waveOutB_q;

    // map a byte address to a register selector
    function automatic cwsd_sel_t decodeAddr(input logic [4:0] addr);
        cwsd_sel_t sel;
        sel = CWSD_SEL_NONE;
        if (addr == CWSD_ADDR_SHUTDOWN_CTRL)
        begin
            sel = CWSD_SEL_CTRL;
        end
        else if (addr == CWSD_ADDR_RISE_COUNT)
        begin
            sel = CWSD_SEL_RISE;
        end
        else if (addr == CWSD_ADDR_FALL_COUNT)
        begin
            sel = CWSD_SEL_FALL;
        end
        else if (addr == CWSD_ADDR_IRQ_STATUS)
        begin
            sel = CWSD_SEL_STAT;
        end
        else if (addr == CWSD_ADDR_IRQ_ENABLE)
        begin
            sel = CWSD_SEL_ENAB;
        end
        else if (addr == CWSD_ADDR_IRQ_CLEAR)
        begin
            sel = CWSD_SEL_CLR;
        end
        return sel;
    endfunction

    // build the control byte; bits 5..2 are unimplemented and read zero
    function automatic logic [7:0] ctlByte(input logic f, input logic r,
        input logic l, input logic t);
        return {f, r, 4'h0, l, t};
    endfunction

    // two flip-flops on each source; only the second stage is read
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            lcMeta_q <= 1'b0;
            lcSync_q <= 1'b0;
            faultMeta_q <= 1'b1;
            faultSync_q <= 1'b1;
        end
        else
        begin
            lcMeta_q <= logic_cell_one_output;
            lcSync_q <= lcMeta_q;
            faultMeta_q <= fault_input;
            faultSync_q <= faultMeta_q;
        end
    end

    // one wait state per access keeps read data on a flop
    assign busSel = decodeAddr(avs_address);
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wrStrobe = avs_write && !avs_waitrequest;
    // all registers live in byte lane 0
    assign lowByteWr = wrStrobe && avs_byteenable[0];
    assign swCtlWr = lowByteWr && (busSel == CWSD_SEL_CTRL);

    // acknowledge flop toggles the handshake
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    // read data captured in the wait cycle, held for the answer cycle
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            readData_q <= CWSD_READ_ZERO;
        end
        else if (avs_read && !ack_q)
        begin
            readData_q <= CWSD_READ_ZERO;
            if (busSel == CWSD_SEL_CTRL)
            begin
                readData_q[7:0] <= ctlByte(shutdown_event_flag,
                    auto_restart_enable, logic_cell_shutdown_enable,
                    fault_shutdown_enable);
            end
            else if (busSel == CWSD_SEL_RISE)
            begin
                // upper bits stay zero
                readData_q[DB_WIDTH-1:0] <= rising_deadband_value;
            end
            else if (busSel == CWSD_SEL_FALL)
            begin
                readData_q[DB_WIDTH-1:0] <= falling_deadband_value;
            end
            else if (busSel == CWSD_SEL_STAT)
            begin
                readData_q[CWSD_IRQ_WIDTH-1:0] <= irqStatus_q;
            end
            else if (busSel == CWSD_SEL_ENAB)
            begin
                readData_q[CWSD_IRQ_WIDTH-1:0] <= irqEnable_q;
            end
        end
    end
    assign avs_readdata = readData_q;

    // any enabled source asks for shutdown
    assign sourceActive = (logic_cell_shutdown_enable && lcSync_q)
        || (fault_shutdown_enable && !faultSync_q);
    assign hwSet = sourceActive && !shutdown_event_flag;
    // restart only when allowed and every enabled source is idle
    assign hwRestart = shutdown_event_flag && auto_restart_enable
        && !sourceActive && !swCtlWr;

    // event flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            shutdown_event_flag <= CWSD_CTRL_RESET[CWSD_BIT_EVENT_FLAG];
        end
        else if (sourceActive)
        begin
            shutdown_event_flag <= 1'b1;
        end
        else if (swCtlWr)
        begin
            // software may force or clear a shutdown
            shutdown_event_flag <= avs_writedata[CWSD_BIT_EVENT_FLAG];
        end
        else if (hwRestart)
        begin
            shutdown_event_flag <= 1'b0;
        end
    end

    // remaining control bits, cleared by rst only; porRst leaves them
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            auto_restart_enable <= CWSD_CTRL_RESET[CWSD_BIT_AUTO_RESTART];
            logic_cell_shutdown_enable <=
                CWSD_CTRL_RESET[CWSD_BIT_LC_ENABLE];
            fault_shutdown_enable <= CWSD_CTRL_RESET[CWSD_BIT_FAULT_ENABLE];
        end
        else if (swCtlWr)
        begin
            auto_restart_enable <= avs_writedata[CWSD_BIT_AUTO_RESTART];
            logic_cell_shutdown_enable <=
                avs_writedata[CWSD_BIT_LC_ENABLE];
            fault_shutdown_enable <= avs_writedata[CWSD_BIT_FAULT_ENABLE];
        end
    end

    // dead-band counts: only power-on reset loads them, rst leaves them
    always_ff @(posedge sys_clk)
    begin
        if (porRst)
        begin
            rising_deadband_value <= DB_WIDTH'(CWSD_DB_POR_RESET);
            falling_deadband_value <= DB_WIDTH'(CWSD_DB_POR_RESET);
        end
        else if (lowByteWr && busSel == CWSD_SEL_RISE)
        begin
            rising_deadband_value <= avs_writedata[DB_WIDTH-1:0];
        end
        else if (lowByteWr && busSel == CWSD_SEL_FALL)
        begin
            falling_deadband_value <= avs_writedata[DB_WIDTH-1:0];
        end
    end

    // sticky interrupt status; a new event wins over a clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irqStatus_q <= CWSD_IRQ_RESET;
        end
        else
        begin
            if (lowByteWr && busSel == CWSD_SEL_CLR)
            begin
                irqStatus_q <= irqStatus_q
                    & ~avs_writedata[CWSD_IRQ_WIDTH-1:0];
            end
            if (hwSet)
            begin
                irqStatus_q[CWSD_IRQ_SHUTDOWN] <= 1'b1;
            end
            if (hwRestart)
            begin
                irqStatus_q[CWSD_IRQ_RESTART] <= 1'b1;
            end
        end
    end

    // interrupt enable register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irqEnable_q <= CWSD_IRQ_RESET;
        end
        else if (lowByteWr && busSel == CWSD_SEL_ENAB)
        begin
            irqEnable_q <= avs_writedata[CWSD_IRQ_WIDTH-1:0];
        end
    end
    assign irq = |(irqStatus_q & irqEnable_q);

    // rising dead band on the true output
    cwsd_edge_delay #(
        .WIDTH(DB_WIDTH)
    ) riseDelay (
        .sys_clk(sys_clk),
        .rst(rst),
        .levelIn(waveIn),
        .delayCount(rising_deadband_value),
        .levelOut(delayedA)
    );

    // falling dead band on the complement output
    cwsd_edge_delay #(
        .WIDTH(DB_WIDTH)
    ) fallDelay (
        .sys_clk(sys_clk),
        .rst(rst),
        .levelIn(!waveIn),
        .delayCount(falling_deadband_value),
        .levelOut(delayedB)
    );

    // output gating; the flag overrides both enables
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            waveOutA_q <= 1'b0;
            waveOutB_q <= 1'b0;
        end
        else
        begin
            waveOutA_q <= delayedA && output_a_enable
                && !shutdown_event_flag;
            waveOutB_q <= delayedB && output_b_enable
                && !shutdown_event_flag;
        end
    end
    assign waveOutA = waveOutA_q;
    assign waveOutB = waveOutB_q;

    // checks kept beside the logic they guard
    AST_SOURCE_SETS_FLAG: assert property (
        @(posedge sys_clk) disable iff (rst)
        sourceActive |=> shutdown_event_flag)
        else $error("enabled source did not set the flag");

    AST_SHUTDOWN_OUTPUTS_OFF: assert property (
        @(posedge sys_clk) disable iff (rst)
        shutdown_event_flag |=> !waveOutA && !waveOutB)
        else $error("output active during shutdown");

    AST_NORMAL_OUTPUT: assert property (
        @(posedge sys_clk) disable iff (rst)
        !shutdown_event_flag && output_a_enable && delayedA |=> waveOutA)
        else $error("output A blocked without shutdown");

    AST_RESTART_BLOCKED: assert property (
        @(posedge sys_clk) disable iff (rst)
        shutdown_event_flag && !auto_restart_enable && !swCtlWr
        |=> shutdown_event_flag)
        else $error("flag cleared with restart disabled");

    AST_AUTO_RESTART: assert property (
        @(posedge sys_clk) disable iff (rst)
        shutdown_event_flag && auto_restart_enable && !sourceActive
        && !swCtlWr |=> !shutdown_event_flag)
        else $error("auto restart did not clear the flag");

    AST_LC_HIGH: assert property (
        @(posedge sys_clk) disable iff (rst)
        logic_cell_shutdown_enable && lcSync_q |=> shutdown_event_flag)
        else $error("logic cell high did not shut down");

    AST_SOURCES_IGNORED: assert property (
        @(posedge sys_clk) disable iff (rst)
        !logic_cell_shutdown_enable && !fault_shutdown_enable
        && !shutdown_event_flag && !swCtlWr |=> !shutdown_event_flag)
        else $error("disabled source caused shutdown");

    AST_FAULT_LOW: assert property (
        @(posedge sys_clk) disable iff (rst)
        fault_shutdown_enable && !faultSync_q |=> shutdown_event_flag)
        else $error("fault low did not shut down");

    AST_CTRL_ZERO_BITS: assert property (
        @(posedge sys_clk) disable iff (rst)
        avs_read && !avs_waitrequest
        |-> avs_readdata[31:8] == 24'h00_0000
        && (busSel != CWSD_SEL_CTRL || avs_readdata[5:2] == 4'h0)
        && (busSel == CWSD_SEL_CTRL || avs_readdata[7:6] == 2'h0))
        else $error("unimplemented bits read nonzero");

    AST_RISE_ONE_COUNT: assert property (
        @(posedge sys_clk) disable iff (rst || porRst)
        $rose(waveIn) && rising_deadband_value == 6'h01
        ##1 waveIn |-> delayedA ##1 waveIn |-> waveOutA == output_a_enable
        || shutdown_event_flag)
        else $error("rising dead band of one count wrong");

    AST_FALL_BYPASS: assert property (
        @(posedge sys_clk) disable iff (rst || porRst)
        falling_deadband_value == 6'h00 && output_b_enable
        && !shutdown_event_flag |=> waveOutB == !$past(waveIn))
        else $error("zero falling count not bypassed");

    AST_COUNTS_KEPT: assert property (
        @(posedge sys_clk)
        rst && !porRst && !wrStrobe |=> $stable(rising_deadband_value)
        && $stable(falling_deadband_value))
        else $error("dead-band count lost across reset");

    AST_RESET_CLEARS_CTRL: assert property (
        @(posedge sys_clk)
        rst |=> !shutdown_event_flag && !auto_restart_enable
        && !logic_cell_shutdown_enable && !fault_shutdown_enable)
        else $error("control bits not cleared by reset");
endmodule

//--- sim/cwsd_shutdown_src.sv
// far-side model of the logic cell output and the external fault pin
`timescale 1ns/10ps
module cwsd_shutdown_src
(
    input wire logic sys_clk,
    input wire logic lcReq,
    input wire logic faultReq,
    output logic logic_cell_one_output,
    output logic fault_input
);
    // idle: logic cell low, fault pin high (it is active low)
    initial
    begin
        logic_cell_one_output = 1'b0;
        fault_input = 1'b1;
    end

    // sources move just after an edge, so the design's sync stages
    // see a clean level; a real source may move at any time
    always @(posedge sys_clk)
    begin
        logic_cell_one_output <= lcReq;
        fault_input <= !faultReq;
    end
endmodule

//--- sim/cwsd_top_test.sv
// self-checking bench for the shutdown and dead-band block
`timescale 1ns/10ps
module cwsd_top_test
    import cwsd_pkg::*;
();
    logic sys_clk = 1'b0; // 100 MHz clock
    logic rst = 1'b1; // synchronous reset
    logic porRst = 1'b1; // power-on reset, clears counts
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic waveIn = 1'b0; // source waveform
    logic oeA = 1'b1; // output enables held on
    logic oeB = 1'b1;
    logic lcReq = 1'b0; // ask the model for a logic cell high
    logic faultReq = 1'b0; // ask the model for a fault low
    logic lcOut;
    logic faultPin;
    logic waveOutA;
    logic waveOutB;
    logic irq;
    int err_count = 0;
    int cmp_count = 0;
    int cnt;
    int n;
    logic [31:0] q;
    logic [5:0] dbVals [4] = '{6'h00, 6'h01, 6'h05, 6'h3F};

    // clock generator
    initial
    begin
        forever #5 sys_clk = !sys_clk;
    end

    cwsd_top cwsd_top_inst (.sys_clk(sys_clk), .rst(rst), .porRst(porRst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .waveIn(waveIn),
        .output_a_enable(oeA), .output_b_enable(oeB),
        .logic_cell_one_output(lcOut), .fault_input(faultPin),
        .waveOutA(waveOutA), .waveOutB(waveOutB), .irq(irq));

    cwsd_shutdown_src cwsd_shutdown_src_inst (.sys_clk(sys_clk),
        .lcReq(lcReq), .faultReq(faultReq),
        .logic_cell_one_output(lcOut), .fault_input(faultPin));

    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon transfer; request held until waitrequest seen low
    task automatic busXfer(input logic wr, input logic [4:0] a,
        input logic [31:0] d, input logic [3:0] be);
        int k;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        for (k = 0; k < 50; k++)
        begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        q = avs_readdata; // read data stands at this edge only
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k == 50)
        begin
            err_count++;
            results();
        end
    endtask

    task automatic wrReg(input logic [4:0] a, input logic [31:0] d);
        busXfer(1'b1, a, d, 4'h1);
    endtask

    task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
        busXfer(1'b0, a, 32'h0000_0000, 4'hF);
        check(q, exp);
    endtask

    // count edges until the chosen output reaches a level
    task automatic waitLvl(input logic useB, input logic lvl);
        for (cnt = 1; cnt < 200; cnt++)
        begin
            @(posedge sys_clk);
            #1;
            if ((useB ? waveOutB : waveOutA) === lvl)
                return;
        end
        err_count++;
        results();
    endtask

    // settle time covers the two sync stages plus the flag update
    task automatic settle();
        repeat (6) @(posedge sys_clk);
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        porRst <= 1'b0;
        // register defaults, reserved bits, refused accesses
        rdChk(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0000);
        rdChk(CWSD_ADDR_IRQ_STATUS, 32'h0000_0000);
        rdChk(CWSD_ADDR_IRQ_ENABLE, 32'h0000_0000);
        wrReg(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_003C);
        rdChk(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0000);
        wrReg(CWSD_ADDR_RISE_COUNT, 32'h0000_00FF);
        rdChk(CWSD_ADDR_RISE_COUNT, 32'h0000_003F);
        wrReg(CWSD_ADDR_FALL_COUNT, 32'h0000_00C5);
        rdChk(CWSD_ADDR_FALL_COUNT, 32'h0000_0005);
        busXfer(1'b1, CWSD_ADDR_RISE_COUNT, 32'h0000_0011, 4'h0);
        rdChk(CWSD_ADDR_RISE_COUNT, 32'h0000_003F);
        rdChk(5'h18, 32'h0000_0000);
        rdChk(CWSD_ADDR_IRQ_CLEAR, 32'h0000_0000);
        // plain reset keeps counts but clears control
        wrReg(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0043);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rdChk(CWSD_ADDR_RISE_COUNT, 32'h0000_003F);
        rdChk(CWSD_ADDR_FALL_COUNT, 32'h0000_0005);
        rdChk(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0000);
        @(posedge sys_clk);
        porRst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        porRst <= 1'b0;
        rdChk(CWSD_ADDR_RISE_COUNT, 32'h0000_0000);
        $display("test registers done");

        // dead band on both edges, zero to full scale
        foreach (dbVals[i])
        begin
            n = dbVals[i];
            wrReg(CWSD_ADDR_RISE_COUNT, {26'h0, dbVals[i]});
            wrReg(CWSD_ADDR_FALL_COUNT, {26'h0, dbVals[i]});
            @(posedge sys_clk);
            waveIn <= 1'b1;
            waitLvl(1'b0, 1'b1);
            check(32'(cnt), 32'(n + 1));
            check({31'h0, waveOutB}, 32'h0000_0000);
            @(posedge sys_clk);
            waveIn <= 1'b0;
            waitLvl(1'b1, 1'b1);
            check(32'(cnt), 32'(n + 1));
        end
        $display("test dead band done");

        // fault shutdown without restart, then software clear
        wrReg(CWSD_ADDR_RISE_COUNT, 32'h0000_0000);
        wrReg(CWSD_ADDR_IRQ_ENABLE, 32'h0000_0001);
        wrReg(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0001);
        @(posedge sys_clk);
        waveIn <= 1'b1;
        waitLvl(1'b0, 1'b1);
        @(posedge sys_clk);
        faultReq <= 1'b1;
        waitLvl(1'b0, 1'b0);
        check({31'h0, cnt > 6}, 32'h0000_0000);
        rdChk(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0081);
        check({31'h0, irq}, 32'h0000_0001);
        rdChk(CWSD_ADDR_IRQ_STATUS, 32'h0000_0001);
        faultReq <= 1'b0;
        settle();
        rdChk(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0081);
        check({31'h0, waveOutA}, 32'h0000_0000);
        wrReg(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0001);
        rdChk(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0001);
        waitLvl(1'b0, 1'b1);
        wrReg(CWSD_ADDR_IRQ_CLEAR, 32'h0000_0001);
        rdChk(CWSD_ADDR_IRQ_STATUS, 32'h0000_0000);
        check({31'h0, irq}, 32'h0000_0000);
        $display("test fault shutdown done");

        // disabled sources have no effect
        wrReg(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0000);
        lcReq <= 1'b1;
        faultReq <= 1'b1;
        settle();
        rdChk(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0000);
        check({31'h0, waveOutA}, 32'h0000_0001);
        faultReq <= 1'b0;
        lcReq <= 1'b0;
        $display("test disabled sources done");

        // logic cell shutdown with auto restart, both sources enabled
        wrReg(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0043);
        lcReq <= 1'b1;
        settle();
        rdChk(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_00C3);
        check({31'h0, waveOutA}, 32'h0000_0000);
        lcReq <= 1'b0;
        settle();
        rdChk(CWSD_ADDR_SHUTDOWN_CTRL, 32'h0000_0043);
        rdChk(CWSD_ADDR_IRQ_STATUS, 32'h0000_0003);
        waitLvl(1'b0, 1'b1);
        wrReg(CWSD_ADDR_IRQ_CLEAR, 32'h0000_0003);
        rdChk(CWSD_ADDR_IRQ_STATUS, 32'h0000_0000);
        $display("test auto restart done");
        results();
    end
endmodule
